// file: hw/htui_cfg.sv
// Configuration bank for the magnetic switch and temperature functions
// Assumes a classic Wishbone master on clk_i with 32-bit data words
//
// Overview of operation
// R1 - Bit 6 of the switch configuration enables output linearization when set.
// R2 - Bits 5 to 4 select touch hysteresis as off, a quarter, an eighth or a sixteenth.
// R3 - Bit 2 of the switch configuration swaps the reported field direction when set.
// R4 - Bits 1 to 0 select proximity hysteresis as off, a quarter, an eighth or a sixteenth.
// R5 - The proximity threshold at 0xA1 is used directly and resets to 0x19.
// R6 - The touch threshold at 0xA2 is multiplied by four, up to 1020.
// R7 - Bit 6 at 0xC0 allows reseeding during proximity only when set.
// R8 - Bit 5 at 0xC0 enables temperature-triggered reseeding.
// R9 - Bits 4 to 0 at 0xC0 hold the reseed threshold used directly.
// R10 - Register 0xC1 holds coarse gain in bits 5 to 4 and fine gain in bits 3 to 0.
// R11 - The calibration multiplier is the byte at 0xC2 plus one.
// R12 - The calibration divider is the byte at 0xC3 plus one.
// R13 - Software avoids writing all ones to the multiplier or divider.
// R14 - The calibration offset at 0xC4 is used directly.
// R15 - Unimplemented bits read as zero, ignore writes and all fields reset.
`timescale 1ns/1ps
module htui_cfg #(
   parameter int NREG = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic prox_active_i,
   input wire logic reseed_req_i,
   output logic reseed_go_o,
   output htui_pkg::htui_switch_s sw_cfg_o,
   output htui_pkg::htui_temp_s temp_cfg_o
);
   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX [NREG] = '{
      htui_pkg::IDX_SW_CFG,
      htui_pkg::IDX_NEAR_THR,
      htui_pkg::IDX_TOUCH_THR,
      htui_pkg::IDX_RESEED_CFG,
      htui_pkg::IDX_CH3_GAIN,
      htui_pkg::IDX_CAL_MUL,
      htui_pkg::IDX_CAL_DIV,
      htui_pkg::IDX_CAL_OFS
   };
   localparam logic [7:0] MASK [NREG] = '{
      htui_pkg::MASK_SW_CFG,
      htui_pkg::MASK_FULL,
      htui_pkg::MASK_FULL,
      htui_pkg::MASK_RESEED_CFG,
      htui_pkg::MASK_CH3_GAIN,
      htui_pkg::MASK_FULL,
      htui_pkg::MASK_FULL,
      htui_pkg::MASK_FULL
   };
   localparam logic [7:0] RST [NREG] = '{
      htui_pkg::RST_SW_CFG,
      htui_pkg::RST_NEAR_THR,
      htui_pkg::RST_TOUCH_THR,
      htui_pkg::RST_TEMP,
      htui_pkg::RST_TEMP,
      htui_pkg::RST_TEMP,
      htui_pkg::RST_TEMP,
      htui_pkg::RST_TEMP
   };

   wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && ce_i;
   wire logic [7:0] idx = wb_adr_i[9:2];
   logic [7:0] q [NREG];
   logic [NREG-1:0] hit;
   logic [7:0] rd_byte;
   wire logic mapped = |hit;
   wire logic lane0 = wb_sel_i[0];
   wire logic wr_req = req && wb_we_i && lane0;
   wire logic rd_req = req && !wb_we_i;

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NREG; g++) begin : g_reg
         assign hit[g] = (idx == IDX[g]);
         htui_reg8 #(.RST(RST[g]), .MASK(MASK[g])) u_reg ( // R15
            .clk_i(clk_i),
            .rst_i(rst_i),
            .we_i(wr_req && hit[g]),
            .d_i(wb_dat_i[7:0]),
            .q_o(q[g])
         );
      end
   endgenerate

   always_comb begin
      rd_byte = 8'h00;
      for (int i = 0; i < NREG; i++) begin
         if (hit[i]) begin
            rd_byte = q[i]; // R15
         end
      end
   end

   // ----------------------------------------------------------------
   // Bus answer, one cycle after the request
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         wb_ack_o <= req && mapped;
         wb_err_o <= req && !mapped;
         wb_dat_o <= (rd_req && mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Switch settings
   // ----------------------------------------------------------------
   wire logic [7:0] swc = q[0];
   wire logic [9:0] touch_thr = 10'(q[2]) << htui_pkg::TOUCH_SCALE_SHIFT; // R6
   logic [7:0] near_band;
   logic [9:0] touch_band;

   htui_hys #(.W(8)) u_near_hys (
      .thr_i(q[1]),
      .sel_i(swc[htui_pkg::SW_PHYS_LSB +: 2]),
      .band_o(near_band)
   ); // R4
   htui_hys #(.W(10)) u_touch_hys (
      .thr_i(touch_thr),
      .sel_i(swc[htui_pkg::SW_THYS_LSB +: 2]),
      .band_o(touch_band)
   ); // R2

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sw_cfg_o <= '0;
      end else if (ce_i) begin
         sw_cfg_o.lin_en <= swc[htui_pkg::SW_LIN_BIT]; // R1
         sw_cfg_o.swap_dir <= swc[htui_pkg::SW_SWAP_BIT]; // R3
         sw_cfg_o.near_thr <= q[1]; // R5
         sw_cfg_o.near_hys <= near_band; // R4
         sw_cfg_o.touch_thr <= touch_thr; // R6
         sw_cfg_o.touch_hys <= touch_band; // R2
      end
   end

   // ----------------------------------------------------------------
   // Temperature settings
   // ----------------------------------------------------------------
   wire logic [7:0] rsc = q[3];
   wire logic rs_prox_ok = rsc[htui_pkg::RS_PROX_BIT];
   wire logic rs_en = rsc[htui_pkg::RS_EN_BIT];
   wire logic next_go = reseed_req_i && rs_en && (rs_prox_ok || !prox_active_i); // R7 R8

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         temp_cfg_o <= '0;
         reseed_go_o <= 1'b0;
      end else if (ce_i) begin
         temp_cfg_o.reseed_in_prox <= rs_prox_ok; // R7
         temp_cfg_o.reseed_en <= rs_en; // R8
         temp_cfg_o.reseed_thr <= rsc[htui_pkg::RS_THR_LSB +: 5]; // R9
         temp_cfg_o.ch3_coarse <= q[4][htui_pkg::CH3_COARSE_LSB +: 2]; // R10
         temp_cfg_o.ch3_fine <= q[4][htui_pkg::CH3_FINE_LSB +: 4]; // R10
         temp_cfg_o.cal_mul <= {1'b0, q[5]} + 9'h001; // R11 R13
         temp_cfg_o.cal_div <= {1'b0, q[6]} + 9'h001; // R12 R13
         temp_cfg_o.cal_ofs <= q[7]; // R14
         reseed_go_o <= next_go;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   touch_scale_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      (ce_i && !rst_i) |=> sw_cfg_o.touch_thr == {$past(q[2]), 2'b00})
      else $error("touch threshold not four times register");
   near_direct_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
      (ce_i && !rst_i) |=> sw_cfg_o.near_thr == $past(q[1]))
      else $error("near threshold mismatch");
   reseed_block_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
      (ce_i && !rst_i && prox_active_i && !rs_prox_ok) |=> !reseed_go_o)
      else $error("reseed during proximity");
   reseed_en_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
      (ce_i && !rst_i && !rs_en) |=> !reseed_go_o)
      else $error("reseed while disabled");
   cal_mul_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
      (ce_i && !rst_i) |=> temp_cfg_o.cal_mul == {1'b0, $past(q[5])} + 9'h001)
      else $error("multiplier not byte plus one");
   cal_div_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
      (ce_i && !rst_i) |=> temp_cfg_o.cal_div == {1'b0, $past(q[6])} + 9'h001)
      else $error("divider not byte plus one");
   unimpl_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
      (q[0][7] == 1'b0) && (q[0][3] == 1'b0) && (q[3][7] == 1'b0) && (q[4][7:6] == 2'b00))
      else $error("unimplemented bit set");
   ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_ack_o && ce_i) |=> !wb_ack_o)
      else $error("ack held two cycles");
   sw_fields_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
      (ce_i && !rst_i) |=> sw_cfg_o.lin_en == $past(swc[6]) && sw_cfg_o.swap_dir == $past(swc[2]))
      else $error("switch flag mismatch");
   ch3_gain_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
      (ce_i && !rst_i) |=> {temp_cfg_o.ch3_coarse, temp_cfg_o.ch3_fine} == $past(q[4][5:0]))
      else $error("channel three gain mismatch");

   // ----------------------------------------------------------------
   // Bus checks
   // ----------------------------------------------------------------
   ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!rst_i && req && mapped) |=> wb_ack_o && !wb_err_o)
      else $error("mapped request not acknowledged");
   err_answer_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
      (!rst_i && req && !mapped) |=> wb_err_o && !wb_ack_o)
      else $error("unmapped request not refused");
   err_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_err_o && ce_i) |=> !wb_err_o)
      else $error("error held two cycles");
   read_data_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
      (!rst_i && rd_req && hit[1]) |=> wb_dat_o == {24'h00_0000, $past(q[1])})
      else $error("read data mismatch");
   read_upper_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
      wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
   write_lands_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
      (!rst_i && wr_req && hit[1]) |=> q[1] == $past(wb_dat_i[7:0]))
      else $error("write did not land");
   sel_guard_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
      (!rst_i && req && wb_we_i && !lane0 && hit[1]) |=> $stable(q[1]))
      else $error("write without lane select changed register");
   masked_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
      (!rst_i && wr_req && hit[0]) |=> q[0] == ($past(wb_dat_i[7:0]) & htui_pkg::MASK_SW_CFG))
      else $error("unimplemented bits written");
   reset_regs_a: assert property (@(posedge clk_i) // R15
      rst_i |=> q[1] == htui_pkg::RST_NEAR_THR && q[2] == htui_pkg::RST_TOUCH_THR && q[0] == '0)
      else $error("register reset value mismatch");
   reset_out_a: assert property (@(posedge clk_i)
      rst_i |=> !wb_ack_o && !wb_err_o && !reseed_go_o)
      else $error("outputs active after reset");
   freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!rst_i && !ce_i) |=> $stable(sw_cfg_o) && $stable(temp_cfg_o) && $stable(wb_ack_o) && $stable(q[1]))
      else $error("state moved with clock enable low");

   // ----------------------------------------------------------------
   // Switch checks
   // ----------------------------------------------------------------
   touch_hys_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
      (ce_i && !rst_i && swc[5:4] == 2'b00) |=> sw_cfg_o.touch_hys == 10'h000)
      else $error("touch hysteresis not off");
   touch_hys_quarter_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
      (ce_i && !rst_i && swc[5:4] == 2'b01) |=> sw_cfg_o.touch_hys == {2'b00, $past(q[2])})
      else $error("touch hysteresis not a quarter");
   touch_hys_eighth_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
      (ce_i && !rst_i && swc[5:4] == 2'b10) |=> sw_cfg_o.touch_hys == {3'b000, $past(q[2][7:1])})
      else $error("touch hysteresis not an eighth");
   touch_hys_sixteenth_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
      (ce_i && !rst_i && swc[5:4] == 2'b11) |=> sw_cfg_o.touch_hys == {4'h0, $past(q[2][7:2])})
      else $error("touch hysteresis not a sixteenth");
   near_hys_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
      (ce_i && !rst_i && swc[1:0] == 2'b00) |=> sw_cfg_o.near_hys == 8'h00)
      else $error("near hysteresis not off");
   near_hys_quarter_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
      (ce_i && !rst_i && swc[1:0] == 2'b01) |=> sw_cfg_o.near_hys == {2'b00, $past(q[1][7:2])})
      else $error("near hysteresis not a quarter");
   near_hys_eighth_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
      (ce_i && !rst_i && swc[1:0] == 2'b10) |=> sw_cfg_o.near_hys == {3'b000, $past(q[1][7:3])})
      else $error("near hysteresis not an eighth");
   near_hys_sixteenth_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
      (ce_i && !rst_i && swc[1:0] == 2'b11) |=> sw_cfg_o.near_hys == {4'h0, $past(q[1][7:4])})
      else $error("near hysteresis not a sixteenth");
   swap_dir_a: assert property (@(posedge clk_i) disable iff (rst_i) // R3
      (ce_i && !rst_i) |=> sw_cfg_o.swap_dir == $past(swc[htui_pkg::SW_SWAP_BIT]))
      else $error("direction swap mismatch");

   // ----------------------------------------------------------------
   // Temperature checks
   // ----------------------------------------------------------------
   reseed_pass_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
      (ce_i && !rst_i && reseed_req_i && rs_en && rs_prox_ok) |=> reseed_go_o)
      else $error("reseed refused during proximity");
   reseed_free_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
      (ce_i && !rst_i && reseed_req_i && rs_en && !prox_active_i) |=> reseed_go_o)
      else $error("enabled reseed refused");
   reseed_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !rst_i && !reseed_req_i) |=> !reseed_go_o)
      else $error("reseed without request");
   reseed_flags_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
      (ce_i && !rst_i) |=> {temp_cfg_o.reseed_in_prox, temp_cfg_o.reseed_en} == $past(q[3][6:5]))
      else $error("reseed flag mismatch");
   reseed_thr_a: assert property (@(posedge clk_i) disable iff (rst_i) // R9
      (ce_i && !rst_i) |=> temp_cfg_o.reseed_thr == $past(q[3][4:0]))
      else $error("reseed threshold mismatch");
   cal_ofs_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
      (ce_i && !rst_i) |=> temp_cfg_o.cal_ofs == $past(q[7]))
      else $error("calibration offset mismatch");
endmodule

// file: hw/htui_pkg.sv
// Package for the magnetic switch and temperature configuration bank
// Assumes a classic Wishbone slave with 8-bit registers in 32-bit words
package htui_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_SW_CFG = 8'hA0;
   localparam logic [7:0] IDX_NEAR_THR = 8'hA1;
   localparam logic [7:0] IDX_TOUCH_THR = 8'hA2;
   localparam logic [7:0] IDX_RESEED_CFG = 8'hC0;
   localparam logic [7:0] IDX_CH3_GAIN = 8'hC1;
   localparam logic [7:0] IDX_CAL_MUL = 8'hC2;
   localparam logic [7:0] IDX_CAL_DIV = 8'hC3;
   localparam logic [7:0] IDX_CAL_OFS = 8'hC4;

   // ----------------------------------------------------------------
   // Writable bit masks
   // ----------------------------------------------------------------
   localparam logic [7:0] MASK_SW_CFG = 8'h77;
   localparam logic [7:0] MASK_RESEED_CFG = 8'h7F;
   localparam logic [7:0] MASK_CH3_GAIN = 8'h3F;
   localparam logic [7:0] MASK_FULL = 8'hFF;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_SW_CFG = 8'h00;
   localparam logic [7:0] RST_NEAR_THR = 8'h19;
   localparam logic [7:0] RST_TOUCH_THR = 8'h19;
   localparam logic [7:0] RST_TEMP = 8'h00;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SW_LIN_BIT = 6;
   localparam int SW_THYS_LSB = 4;
   localparam int SW_SWAP_BIT = 2;
   localparam int SW_PHYS_LSB = 0;
   localparam int RS_PROX_BIT = 6;
   localparam int RS_EN_BIT = 5;
   localparam int RS_THR_LSB = 0;
   localparam int CH3_COARSE_LSB = 4;
   localparam int CH3_FINE_LSB = 0;
   localparam int TOUCH_SCALE_SHIFT = 2;

   typedef enum logic [1:0] {
      HTUI_HYS_OFF,
      HTUI_HYS_QUARTER,
      HTUI_HYS_EIGHTH,
      HTUI_HYS_SIXTEENTH
   } htui_hys_e;

   typedef struct packed {
      logic lin_en;
      logic swap_dir;
      logic [7:0] near_thr;
      logic [7:0] near_hys;
      logic [9:0] touch_thr;
      logic [9:0] touch_hys;
   } htui_switch_s;

   typedef struct packed {
      logic reseed_in_prox;
      logic reseed_en;
      logic [4:0] reseed_thr;
      logic [1:0] ch3_coarse;
      logic [3:0] ch3_fine;
      logic [8:0] cal_mul;
      logic [8:0] cal_div;
      logic [7:0] cal_ofs;
   } htui_temp_s;

endpackage

// file: hw/htui_hys.sv
// Hysteresis band from a threshold and a two-bit fraction selection
// Assumes combinational use on the same clock as its caller
`timescale 1ns/1ps
module htui_hys #(
   parameter int W = 8
) (
   input wire logic [W-1:0] thr_i,
   input wire logic [1:0] sel_i,
   output logic [W-1:0] band_o
);
   wire logic [W-1:0] quarter = thr_i >> 2;
   wire logic [W-1:0] eighth = thr_i >> 3;
   wire logic [W-1:0] sixteenth = thr_i >> 4;

   assign band_o = (sel_i == htui_pkg::HTUI_HYS_QUARTER) ? quarter :
                   (sel_i == htui_pkg::HTUI_HYS_EIGHTH) ? eighth :
                   (sel_i == htui_pkg::HTUI_HYS_SIXTEENTH) ? sixteenth : '0;
endmodule

// file: hw/htui_reg8.sv
// One 8-bit configuration register with a writable bit mask
// Assumes write strobe qualified by the bus and clock enable upstream
`timescale 1ns/1ps
module htui_reg8 #(
   parameter logic [7:0] RST = 8'h00,
   parameter logic [7:0] MASK = 8'hFF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic we_i,
   input wire logic [7:0] d_i,
   output logic [7:0] q_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_o <= RST & MASK;
      end else if (we_i) begin
         q_o <= d_i & MASK;
      end
   end
endmodule

// file: sim/htui_cfg_tb.sv
// Self-checking bench for the magnetic switch and temperature configuration bank
// Assumes a 250 MHz clock, synchronous reset and a classic Wishbone master
`timescale 1ns/1ps
module htui_cfg_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, prox = 1'b0, req = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0, wb_dat_o;
   logic wb_ack_o, wb_err_o, reseed_go_o;
   htui_pkg::htui_switch_s sw;
   htui_pkg::htui_temp_s tp;
   int err_count = 0, checks = 0, seed = 98223;
   logic [7:0] sh [8];
   logic [7:0] idx_t [8] = '{8'hA0, 8'hA1, 8'hA2, 8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4};
   logic [7:0] msk_t [8] = '{8'h77, 8'hFF, 8'hFF, 8'h7F, 8'h3F, 8'hFF, 8'hFF, 8'hFF};
   logic [7:0] rst_t [8] = '{8'h00, 8'h19, 8'h19, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [31:0] q;
   logic e;
   always #2 clk_i = ~clk_i;
   htui_cfg htui_cfg_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .prox_active_i(prox),
      .reseed_req_i(req), .reseed_go_o(reseed_go_o), .sw_cfg_o(sw), .temp_cfg_o(tp));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   function automatic logic [9:0] hys(input logic [9:0] t, input logic [1:0] s);
      case (s)
         2'd0: return 10'h000;
         2'd1: return t >> 2;
         2'd2: return t >> 3;
         default: return t >> 4;
      endcase
   endfunction
   task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d,
      input logic s0);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {ix, 2'b00};
      sel <= {3'b000, s0};
      dat <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         $display("ERROR t=%0t bus answer missing", $time);
      end
      q = wb_dat_o;
      e = wb_err_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input int k, input logic [7:0] d);
      bus(1'b1, idx_t[k], d, 1'b1);
      sh[k] = d & msk_t[k];
      check(e, 1'b0);
   endtask
   task automatic rd_all();
      for (int k = 0; k < 8; k++) begin
         bus(1'b0, idx_t[k], 8'h00, 1'b0);
         check(q, {24'h0, sh[k]});
      end
   endtask
   task automatic check_outs();
      repeat (2) @(posedge clk_i);
      check(sw.lin_en, sh[0][6]);
      check(sw.touch_hys, hys({sh[2], 2'b00}, sh[0][5:4]));
      check(sw.swap_dir, sh[0][2]);
      check(sw.near_hys, hys({2'b00, sh[1]}, sh[0][1:0]));
      check(sw.near_thr, sh[1]);
      check(sw.touch_thr, {sh[2], 2'b00});
      check(tp.reseed_in_prox, sh[3][6]);
      check(tp.reseed_en, sh[3][5]);
      check(tp.reseed_thr, sh[3][4:0]);
      check({tp.ch3_coarse, tp.ch3_fine}, sh[4][5:0]);
      check(tp.cal_mul, {1'b0, sh[5]} + 9'd1);
      check(tp.cal_div, {1'b0, sh[6]} + 9'd1);
      check(tp.cal_ofs, sh[7]);
   endtask
   task automatic do_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int k = 0; k < 8; k++) sh[k] = rst_t[k];
      check_outs();
      rd_all();
      $display("reset test done");
   endtask
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] d;
      do_reset();
      for (int k = 0; k < 8; k++) wr(k, (k == 5 || k == 6) ? 8'hFE : 8'hFF);
      check_outs();
      rd_all();
      for (int r = 0; r < 12; r++) begin
         for (int k = 0; k < 8; k++) begin
            d = 8'($random(seed));
            if ((k == 5 || k == 6) && d == 8'hFF) d = 8'hFE;
            wr(k, d);
         end
         check_outs();
         rd_all();
      end
      $display("random write test done");
      bus(1'b1, idx_t[1], ~sh[1], 1'b0);
      check(e, 1'b0);
      bus(1'b1, 8'hA3, 8'h55, 1'b1);
      check(e, 1'b1);
      bus(1'b0, 8'hC5, 8'h00, 1'b0);
      check(e, 1'b1);
      check(q, 32'h0);
      rd_all();
      $display("refused access test done");
      @(posedge clk_i);
      ce_i <= 1'b0;
      fork
         bus(1'b1, idx_t[7], ~sh[7], 1'b1);
         begin
            repeat (5) @(posedge clk_i);
            check(wb_ack_o, 1'b0);
            check(tp.cal_ofs, sh[7]);
            ce_i <= 1'b1;
         end
      join
      sh[7] = ~sh[7];
      check(e, 1'b0);
      check_outs();
      rd_all();
      $display("clock enable test done");
      for (int c = 0; c < 8; c++) begin
         wr(3, {1'b0, c[2], c[1], 5'h05});
         @(posedge clk_i);
         prox <= c[0];
         req <= 1'b1;
         @(posedge clk_i);
         req <= 1'b0;
         @(negedge clk_i);
         check(reseed_go_o, c[1] & (c[2] | ~c[0]));
      end
      prox <= 1'b0;
      check_outs();
      $display("reseed gating test done");
      do_reset();
      final_report();
   end
   initial begin
      #200000;
      err_count++;
      final_report();
   end
endmodule
